// ==== design/mu_dsp_side.sv ====
// Contract
// - transmit irq per channel while its enable and tx-empty are both set
// - receive irq per channel while its enable and rx-full are both set
// - maskable command irq needs enable, pending and non-maskable select clear
// - with non-maskable select set, pending alone raises the non-maskable irq
// - no control-enabled irq while the unit priority field is zero
// - dsp-to-host flag bits are mirrored continuously to the host side
// - tx-empty shows host has read latest word; resets to one
// - rx-full set by host transmit write, cleared by dsp read; resets zero
// - writing one sets a general request; host clearing its pending clears it
// - timer clear strobe clears timer status and its lines; reads zero
// - command pending set by host command bit, cleared when serviced
// - wake clear strobe clears wake request and its lines
// - two-bit read-only host power mode: stop, wait, doze, normal
// - event pending set on update request, cleared on acknowledge
// - status flag bits mirror the host-to-dsp flags
// - write-one bits act only on a one; zero has no effect
// - host read of a receive register sets the matching tx-empty bit
// - unit soft reset returns control and status bits to defaults, except the mirrored power mode and host flags
`timescale 1ns/10ps
`default_nettype none
module mu_dsp_side (
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic [19:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output wire logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output wire logic        S_AXI_WREADY,
  output wire logic [1:0]  S_AXI_BRESP,
  output wire logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [19:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output wire logic        S_AXI_ARREADY,
  output wire logic [31:0] S_AXI_RDATA,
  output wire logic [1:0]  S_AXI_RRESP,
  output wire logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        UNIT_SOFT_RESET,
  input  wire logic [1:0]  IRQ_PRIORITY,
  input  wire logic [1:0]  HOST_TX_WR,
  input  wire logic [1:0]  HOST_RX_RD,
  input  wire logic [1:0]  DSP_TX_WR,
  input  wire logic [1:0]  DSP_RX_RD,
  input  wire logic [1:0]  HOST_GEN_CLR,
  input  wire logic        HOST_CMD_SET,
  input  wire logic        HOST_NMI_SEL,
  input  wire logic        CMD_SERVICED,
  input  wire logic        HOST_TIMER_SET,
  input  wire logic        HOST_WAKE_SET,
  input  wire logic [1:0]  HOST_POWER_MODE,
  input  wire logic [2:0]  HOST_FLAGS,
  input  wire logic        EVENT_ACK,
  output wire logic [1:0]  TX_IRQ,
  output wire logic [1:0]  RX_IRQ,
  output wire logic        CMD_IRQ,
  output wire logic        CMD_NMI,
  output wire logic [1:0]  GENERAL_REQ,
  output wire logic        TIMER_IRQ,
  output wire logic        WAKE_IRQ,
  output wire logic        WIRED_OR_IRQ,
  output wire logic [2:0]  DSP_TO_HOST_FLAGS,
  output wire logic        EVENT_REQ
);

  mu_pkg::mu_state_type cur;
  mu_pkg::mu_state_type next;
  mu_event_if           ev ();

  logic        wr_fire;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_hit;
  logic [15:0] byte_mask;
  logic [15:0] ones;
  logic [15:0] stat_view;
  logic        rd_ctrl;
  logic        rd_stat;
  logic        ev_fire;

  mu_event_link u_link (
    .clk  (CLK_SYS),
    .srst (SRST),
    .ev   (ev)
  );

  assign ev.evt = ev_fire;
  assign ev.ack = EVENT_ACK;
  assign ev.clr = UNIT_SOFT_RESET;

  // status as software reads it; strobe bits 9 and 7 always read zero
  assign stat_view = {cur.tx_empty[0], cur.tx_empty[1],
                      cur.rx_full[0], cur.rx_full[1],
                      cur.gen_req[0], cur.gen_req[1],
                      1'b0, cur.cmd_pending, 1'b0,
                      cur.power_mode, ev.pending, 1'b0,
                      cur.host_flags};

  assign wr_fire   = (cur.wst == mu_pkg::WR_IDLE) && cur.aw_got && cur.w_got;
  assign wr_ctrl   = wr_fire && (cur.aw_addr == mu_pkg::CTRL_ADDR);
  assign wr_stat   = wr_fire && (cur.aw_addr == mu_pkg::STAT_ADDR);
  assign wr_hit    = wr_ctrl || wr_stat;
  assign byte_mask = {{8{cur.w_strb[1]}}, {8{cur.w_strb[0]}}};
  assign ones      = wr_stat ? (cur.w_data[15:0] & byte_mask) : 16'h0000;
  assign rd_ctrl   = (S_AXI_ARADDR == mu_pkg::CTRL_ADDR);
  assign rd_stat   = (S_AXI_ARADDR == mu_pkg::STAT_ADDR);

  always_comb begin
    next    = cur;
    ev_fire = 1'b0;

    // write address and data are taken in either order
    if (cur.aw_rdy && S_AXI_AWVALID) begin
      next.aw_rdy  = 1'b0;
      next.aw_got  = 1'b1;
      next.aw_addr = S_AXI_AWADDR;
    end
    if (cur.w_rdy && S_AXI_WVALID) begin
      next.w_rdy  = 1'b0;
      next.w_got  = 1'b1;
      next.w_data = S_AXI_WDATA;
      next.w_strb = S_AXI_WSTRB;
    end
    case (cur.wst)
      mu_pkg::WR_IDLE: begin
        if (wr_fire) begin
          next.aw_got = 1'b0;
          next.w_got  = 1'b0;
          next.bvalid = 1'b1;
          next.bresp  = wr_hit ? mu_pkg::RESP_OKAY : mu_pkg::RESP_SLVERR;
          next.wst    = mu_pkg::WR_RESP;
        end
      end
      mu_pkg::WR_RESP: begin
        if (S_AXI_BREADY) begin
          next.bvalid = 1'b0;
          next.aw_rdy = 1'b1;
          next.w_rdy  = 1'b1;
          next.wst    = mu_pkg::WR_IDLE;
        end
      end
      default: begin
        next.wst = mu_pkg::WR_IDLE;
      end
    endcase

    // read: one cycle from address to data
    if (cur.ar_rdy && S_AXI_ARVALID) begin
      next.ar_rdy = 1'b0;
      next.rvalid = 1'b1;
      if (rd_ctrl) begin
        next.rdata = {16'h0000, cur.ctrl};
        next.rresp = mu_pkg::RESP_OKAY;
      end else if (rd_stat) begin
        next.rdata = {16'h0000, stat_view};
        next.rresp = mu_pkg::RESP_OKAY;
      end else begin
        next.rdata = 32'h00000000;
        next.rresp = mu_pkg::RESP_SLVERR;
      end
    end else if (cur.rvalid && S_AXI_RREADY) begin
      next.rvalid = 1'b0;
      next.ar_rdy = 1'b1;
    end

    if (wr_ctrl) begin
      next.ctrl = ((cur.ctrl & ~byte_mask) | (cur.w_data[15:0] & byte_mask))
                  & mu_pkg::CTRL_MASK;
    end

    // in every flag below a set in the same cycle wins over its clear
    for (int c = 0; c < mu_pkg::NCH; c++) begin
      if (DSP_RX_RD[c]) begin
        next.rx_full[c] = 1'b0;
      end
      if (HOST_TX_WR[c]) begin
        next.rx_full[c] = 1'b1;
      end
      if (DSP_TX_WR[c]) begin
        next.tx_empty[c] = 1'b0;
      end
      if (HOST_RX_RD[c]) begin
        next.tx_empty[c] = 1'b1;
      end
      if (HOST_GEN_CLR[c]) begin
        next.gen_req[c] = 1'b0;
      end
      if (ones[mu_pkg::B_GEN0 - c]) begin
        next.gen_req[c] = 1'b1;
      end
    end

    if (CMD_SERVICED) begin
      next.cmd_pending = 1'b0;
    end
    if (HOST_CMD_SET) begin
      next.cmd_pending = 1'b1;
    end
    if (ones[mu_pkg::B_TCLR]) begin
      next.timer_status = 1'b0;
    end
    if (HOST_TIMER_SET) begin
      next.timer_status = 1'b1;
    end
    if (ones[mu_pkg::B_WCLR]) begin
      next.wake_req = 1'b0;
    end
    if (HOST_WAKE_SET) begin
      next.wake_req = 1'b1;
    end

    // dsp transmit writes, dsp receive reads and write-one status bits raise an update request
    ev_fire = (|DSP_TX_WR) || (|DSP_RX_RD)
              || (|(ones & mu_pkg::STAT_W1_MASK));

    if (UNIT_SOFT_RESET) begin
      next.ctrl         = mu_pkg::CTRL_RST;
      next.tx_empty     = mu_pkg::TX_EMPTY_RST;
      next.rx_full      = mu_pkg::RX_FULL_RST;
      next.gen_req      = 2'h0;
      next.cmd_pending  = 1'b0;
      next.timer_status = 1'b0;
      next.wake_req     = 1'b0;
      ev_fire           = 1'b0;
    end

    next.host_flags = HOST_FLAGS;
    next.power_mode = HOST_POWER_MODE;
    next.prio_ok    = (IRQ_PRIORITY != 2'h0);
    next.nmi_sel    = HOST_NMI_SEL;

    // levels, recomputed every cycle from the coming state
    for (int c = 0; c < mu_pkg::NCH; c++) begin
      next.tx_irq[c] = next.prio_ok && next.tx_empty[c]
                       && next.ctrl[mu_pkg::B_TX_EN0 - c];
      next.rx_irq[c] = next.prio_ok && next.rx_full[c]
                       && next.ctrl[mu_pkg::B_RX_EN0 - c];
    end
    next.cmd_irq = next.prio_ok && next.ctrl[mu_pkg::B_CMD_EN]
                   && next.cmd_pending && !next.nmi_sel;
    next.cmd_nmi = next.cmd_pending && next.nmi_sel;
    next.wor_irq = next.timer_status | next.wake_req;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      cur <= mu_pkg::STATE_RST;
    end else begin
      cur <= next;
    end
  end

  assign S_AXI_AWREADY     = cur.aw_rdy;
  assign S_AXI_WREADY      = cur.w_rdy;
  assign S_AXI_BVALID      = cur.bvalid;
  assign S_AXI_BRESP       = cur.bresp;
  assign S_AXI_ARREADY     = cur.ar_rdy;
  assign S_AXI_RVALID      = cur.rvalid;
  assign S_AXI_RDATA       = cur.rdata;
  assign S_AXI_RRESP       = cur.rresp;
  assign TX_IRQ            = cur.tx_irq;
  assign RX_IRQ            = cur.rx_irq;
  assign CMD_IRQ           = cur.cmd_irq;
  assign CMD_NMI           = cur.cmd_nmi;
  assign GENERAL_REQ       = cur.gen_req;
  assign TIMER_IRQ         = cur.timer_status;
  assign WAKE_IRQ          = cur.wake_req;
  assign WIRED_OR_IRQ      = cur.wor_irq;
  assign DSP_TO_HOST_FLAGS = cur.ctrl[mu_pkg::B_FLAG_HI:0];
  assign EVENT_REQ         = ev.pending;

  genvar g;
  generate
    for (g = 0; g < mu_pkg::NCH; g++) begin : g_ch
      a_tx_irq_level:
      assert property (@(posedge CLK_SYS) disable iff (SRST)
        ##1 TX_IRQ[g] == (cur.ctrl[mu_pkg::B_TX_EN0 - g]
          && cur.tx_empty[g] && ($past(IRQ_PRIORITY) != 2'h0)))
        else $error("transmit irq does not follow enable and empty");

      a_rx_irq_level:
      assert property (@(posedge CLK_SYS) disable iff (SRST)
        ##1 RX_IRQ[g] == (cur.ctrl[mu_pkg::B_RX_EN0 - g]
          && cur.rx_full[g] && ($past(IRQ_PRIORITY) != 2'h0)))
        else $error("receive irq does not follow enable and full");

      a_rx_full_set:
      assert property (@(posedge CLK_SYS) disable iff (SRST)
        HOST_TX_WR[g] && !UNIT_SOFT_RESET |=> cur.rx_full[g])
        else $error("host transmit write did not set rx-full");

      a_host_read_empty:
      assert property (@(posedge CLK_SYS) disable iff (SRST)
        HOST_RX_RD[g] && !UNIT_SOFT_RESET |=> cur.tx_empty[g]
          ##1 (TX_IRQ[g] || !cur.ctrl[mu_pkg::B_TX_EN0 - g]
               || $past(IRQ_PRIORITY) == 2'h0 || !cur.tx_empty[g]))
        else $error("host read did not set tx-empty");
    end
  endgenerate

  a_cmd_mask_gate:
  assert property (@(posedge CLK_SYS) disable iff (SRST)
    CMD_IRQ |-> cur.cmd_pending && !$past(HOST_NMI_SEL)
      && cur.ctrl[mu_pkg::B_CMD_EN] && $past(IRQ_PRIORITY) != 2'h0)
    else $error("maskable command irq without its conditions");

  a_cmd_nmi_path:
  assert property (@(posedge CLK_SYS) disable iff (SRST)
    HOST_CMD_SET && HOST_NMI_SEL && !UNIT_SOFT_RESET |=> CMD_NMI && !CMD_IRQ)
    else $error("non-maskable command irq not raised");

  a_prio_zero_gate:
  assert property (@(posedge CLK_SYS) disable iff (SRST)
    IRQ_PRIORITY == 2'h0 |=> TX_IRQ == 2'h0 && RX_IRQ == 2'h0 && !CMD_IRQ)
    else $error("irq raised with zero priority");

  a_timer_clear:
  assert property (@(posedge CLK_SYS) disable iff (SRST)
    ones[mu_pkg::B_TCLR] && !HOST_TIMER_SET
      |=> !TIMER_IRQ && (WIRED_OR_IRQ == WAKE_IRQ))
    else $error("timer clear strobe did not release the timer line");

  a_wake_clear:
  assert property (@(posedge CLK_SYS) disable iff (SRST)
    ones[mu_pkg::B_WCLR] && !HOST_WAKE_SET |=> !WAKE_IRQ)
    else $error("wake clear strobe did not release the wake line");

  a_zero_write_idle:
  assert property (@(posedge CLK_SYS) disable iff (SRST)
    wr_stat && !cur.w_data[mu_pkg::B_TCLR] && !HOST_TIMER_SET
      |=> TIMER_IRQ == $past(TIMER_IRQ))
    else $error("writing zero to a strobe changed the timer status");

  a_cmd_pend_set:
  assert property (@(posedge CLK_SYS) disable iff (SRST)
    HOST_CMD_SET && !UNIT_SOFT_RESET |=> cur.cmd_pending)
    else $error("host command bit did not set command pending");

  a_event_handshake:
  assert property (@(posedge CLK_SYS) disable iff (SRST)
    ev_fire |=> EVENT_REQ)
    else $error("event request not raised");

  a_event_hold:
  assert property (@(posedge CLK_SYS) disable iff (SRST)
    EVENT_REQ && !EVENT_ACK && !UNIT_SOFT_RESET |=> EVENT_REQ)
    else $error("event request dropped before acknowledge");

  a_soft_reset_all:
  assert property (@(posedge CLK_SYS) disable iff (SRST)
    UNIT_SOFT_RESET |=> cur.ctrl == mu_pkg::CTRL_RST && !EVENT_REQ
      && cur.tx_empty == mu_pkg::TX_EMPTY_RST && !TIMER_IRQ && !WAKE_IRQ)
    else $error("soft reset left a bit away from its default");

endmodule
`default_nettype wire

// ==== pkg/mu_pkg.sv ====
package mu_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int PRIO_W = 2;
  localparam int NCH    = 2;

  // register indices; the byte address is four times the index
  localparam logic [15:0] CTRL_IDX = 16'hFF8A;
  localparam logic [15:0] STAT_IDX = 16'hFF8B;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

  // control register fields; channel n enable sits at base minus n
  localparam int B_TX_EN0  = 15;
  localparam int B_RX_EN0  = 13;
  localparam int B_CMD_EN  = 8;
  localparam int B_FLAG_HI = 2;

  // status register write-one fields
  localparam int B_GEN0 = 11;
  localparam int B_TCLR = 9;
  localparam int B_WCLR = 7;

  localparam logic [REG_W-1:0] CTRL_MASK    = 16'hF107;
  localparam logic [REG_W-1:0] CTRL_RST     = 16'h0000;
  localparam logic [REG_W-1:0] STAT_W1_MASK = 16'h0E80;
  localparam logic [NCH-1:0]   TX_EMPTY_RST = 2'h3;
  localparam logic [NCH-1:0]   RX_FULL_RST  = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } mu_wr_state_type;

  typedef struct packed {
    mu_wr_state_type    wst;
    logic               aw_rdy;
    logic               w_rdy;
    logic               aw_got;
    logic               w_got;
    logic [ADDR_W-1:0]  aw_addr;
    logic [DATA_W-1:0]  w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               ar_rdy;
    logic               rvalid;
    logic [DATA_W-1:0]  rdata;
    logic [1:0]         rresp;
    logic [REG_W-1:0]   ctrl;
    logic [NCH-1:0]     tx_empty;
    logic [NCH-1:0]     rx_full;
    logic [NCH-1:0]     gen_req;
    logic               cmd_pending;
    logic               timer_status;
    logic               wake_req;
    logic [2:0]         host_flags;
    logic [1:0]         power_mode;
    logic               prio_ok;
    logic               nmi_sel;
    logic [NCH-1:0]     tx_irq;
    logic [NCH-1:0]     rx_irq;
    logic               cmd_irq;
    logic               cmd_nmi;
    logic               wor_irq;
  } mu_state_type;

  localparam mu_state_type STATE_RST = '{
    wst: WR_IDLE, aw_rdy: 1'b1, w_rdy: 1'b1, aw_got: 1'b0, w_got: 1'b0,
    aw_addr: '0, w_data: '0, w_strb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY,
    ar_rdy: 1'b1, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY,
    ctrl: CTRL_RST, tx_empty: TX_EMPTY_RST, rx_full: RX_FULL_RST,
    gen_req: 2'h0, cmd_pending: 1'b0, timer_status: 1'b0, wake_req: 1'b0,
    host_flags: 3'h0, power_mode: 2'h0, prio_ok: 1'b0, nmi_sel: 1'b0,
    tx_irq: 2'h0, rx_irq: 2'h0, cmd_irq: 1'b0, cmd_nmi: 1'b0,
    wor_irq: 1'b0};

  typedef struct packed {
    logic pending;
  } mu_link_state_type;

endpackage

// ==== pkg/mu_event_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface mu_event_if;
  logic evt;
  logic ack;
  logic clr;
  logic pending;
  modport main (output evt, output ack, output clr, input pending);
  modport link (input evt, input ack, input clr, output pending);
endinterface
`default_nettype wire

// ==== design/mu_event_link.sv ====
`timescale 1ns/10ps
`default_nettype none
module mu_event_link (
  input wire logic clk,
  input wire logic srst,
  mu_event_if.link ev
);

  mu_pkg::mu_link_state_type cur;
  mu_pkg::mu_link_state_type next;

  // a new event in the acknowledge cycle keeps the request pending
  always_comb begin
    next = cur;
    if (ev.ack) begin
      next.pending = 1'b0;
    end
    if (ev.evt) begin
      next.pending = 1'b1;
    end
    if (ev.clr) begin
      next.pending = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur <= '{pending: 1'b0};
    end else begin
      cur <= next;
    end
  end

  assign ev.pending = cur.pending;

endmodule
`default_nettype wire

// ==== tb/mu_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// host-side partner: acknowledges event updates and services general
// requests after a short or a long delay
module mu_host_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       slow,
  input  wire logic       event_req,
  input  wire logic [1:0] general_req,
  output logic            event_ack,
  output logic [1:0]      gen_clr
);
  logic [3:0] ecnt;
  logic [3:0] gcnt;
  logic [3:0] dly;

  assign dly = slow ? 4'h8 : 4'h2;

  always_ff @(posedge clk) begin
    event_ack <= 1'b0;
    gen_clr   <= 2'h0;
    if (srst || !event_req) begin
      ecnt <= 4'h0;
    end else if (ecnt == dly) begin
      event_ack <= 1'b1;
      ecnt      <= 4'h0;
    end else begin
      ecnt <= ecnt + 4'h1;
    end
    if (srst || general_req == 2'h0) begin
      gcnt <= 4'h0;
    end else if (gcnt == dly) begin
      gen_clr <= general_req;
      gcnt    <= 4'h0;
    end else begin
      gcnt <= gcnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/dsp_side_message_unit_regs_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module dsp_side_message_unit_regs_tb_top;
  localparam logic [19:0] ca  = mu_pkg::CTRL_ADDR;
  localparam logic [19:0] sa  = mu_pkg::STAT_ADDR;
  localparam logic [1:0]  ok  = mu_pkg::RESP_OKAY;
  localparam logic [1:0]  err = mu_pkg::RESP_SLVERR;
  logic        clk_sys, srst, slow, nmi;
  logic [19:0] aw_addr, ar_addr;
  logic [31:0] w_data, r_data, rdat;
  logic        aw_valid, w_valid, b_ready, ar_valid, r_ready;
  logic        aw_ready, w_ready, b_valid, r_valid;
  logic        ar_ready_w;
  logic [3:0]  w_strb, strb;
  logic [1:0]  b_resp, r_resp, rrsp, prio, pm, gen_clr;
  logic [1:0]  tx_irq, rx_irq, gen_req;
  logic [2:0]  hflags, d2h;
  logic [12:0] pulses;
  logic        ev_ack, ev_req, cmd_irq, cmd_nmi, tmr_irq, wake_irq, wor_irq;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;

  mu_dsp_side mu_dsp_side_i (
    .CLK_SYS(clk_sys), .SRST(srst),
    .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data),
    .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
    .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
    .S_AXI_ARREADY(ar_ready_w), .S_AXI_RDATA(r_data),
    .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready),
    .UNIT_SOFT_RESET(pulses[12]), .IRQ_PRIORITY(prio),
    .HOST_TX_WR(pulses[1:0]), .HOST_RX_RD(pulses[3:2]),
    .DSP_TX_WR(pulses[5:4]), .DSP_RX_RD(pulses[7:6]),
    .HOST_GEN_CLR(gen_clr), .HOST_CMD_SET(pulses[8]),
    .HOST_NMI_SEL(nmi), .CMD_SERVICED(pulses[9]),
    .HOST_TIMER_SET(pulses[10]), .HOST_WAKE_SET(pulses[11]),
    .HOST_POWER_MODE(pm), .HOST_FLAGS(hflags), .EVENT_ACK(ev_ack),
    .TX_IRQ(tx_irq), .RX_IRQ(rx_irq), .CMD_IRQ(cmd_irq), .CMD_NMI(cmd_nmi),
    .GENERAL_REQ(gen_req), .TIMER_IRQ(tmr_irq), .WAKE_IRQ(wake_irq),
    .WIRED_OR_IRQ(wor_irq), .DSP_TO_HOST_FLAGS(d2h), .EVENT_REQ(ev_req)
  );

  mu_host_model mu_host_model_i (
    .clk(clk_sys), .srst(srst), .slow(slow), .event_req(ev_req),
    .general_req(gen_req), .event_ack(ev_ack), .gen_clr(gen_clr)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e,
                         input logic [31:0] m);
    checked++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("mismatch at %0t: register got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic [3:0] g, input logic [3:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: outputs got %h want %h", $time, g, e);
    end
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic pulse(input logic [12:0] p);
    @(posedge clk_sys);
    pulses <= p;
    @(posedge clk_sys);
    pulses <= 13'h0000;
    settle;
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk_sys);
    aw_addr  <= a;
    w_data   <= d;
    w_strb   <= strb;
    aw_valid <= 1'b1;
    w_valid  <= 1'b1;
    b_ready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid) break;
    end
    b_ready <= 1'b0;
    chk_reg({30'h0, b_resp}, {30'h0, er}, 32'h3);
  endtask

  task automatic rd(input logic [19:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    ar_addr  <= a;
    ar_valid <= 1'b1;
    r_ready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (ar_valid && ar_ready_w) ar_valid <= 1'b0;
      if (r_valid) break;
    end
    d = r_data;
    r = r_resp;
    r_ready <= 1'b0;
  endtask

  task automatic rc(input logic [19:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk_reg(d, e, m);
    chk_reg({30'h0, r}, {30'h0, er}, 32'h3);
  endtask

  initial begin
    {aw_addr, ar_addr, w_data, aw_valid, w_valid, b_ready} = '0;
    {strb, w_strb} = 8'hFF;
    {ar_valid, r_ready, prio, pm, hflags, nmi, slow, pulses} = '0;
    srst = 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rc(sa, 32'hC000, 32'hFFFFFFEF, ok);
    rc(20'h00010, 32'h0, 32'hFFFFFFFF, err);
    wr(20'h00010, 32'hFFFF, err);
    rc(ca, 32'h0, 32'hFFFFFFFF, ok);
    wr(ca, 32'hFFFFFFFF, ok);
    rc(ca, 32'hF107, 32'hFFFFFFFF, ok);
    settle;
    chk_pin({1'b0, d2h}, 4'h7);
    chk_pin({tx_irq, rx_irq}, 4'h0);
    @(posedge clk_sys);
    prio <= 2'h1;
    settle;
    chk_pin({tx_irq, rx_irq}, 4'hC);
    wr(ca, 32'h7107, ok);
    settle;
    chk_pin({tx_irq, rx_irq}, 4'h8);
    wr(ca, 32'hF107, ok);
    pulse(13'h0010);
    chk_pin({tx_irq, rx_irq}, 4'h8);
    rc(sa, 32'h4000, 32'hC000, ok);
    pulse(13'h0004);
    chk_pin({tx_irq, rx_irq}, 4'hC);
    pulse(13'h0002);
    chk_pin({tx_irq, rx_irq}, 4'hE);
    pulse(13'h0080);
    chk_pin({tx_irq, rx_irq}, 4'hC);
    pulse(13'h0100);
    chk_pin({2'h0, cmd_irq, cmd_nmi}, 4'h2);
    rc(sa, 32'h0100, 32'h0100, ok);
    @(posedge clk_sys);
    nmi <= 1'b1;
    settle;
    chk_pin({2'h0, cmd_irq, cmd_nmi}, 4'h1);
    wr(ca, 32'h0, ok);
    @(posedge clk_sys);
    prio <= 2'h0;
    settle;
    chk_pin({tx_irq, cmd_irq, cmd_nmi}, 4'h1);
    pulse(13'h0200);
    chk_pin({2'h0, cmd_irq, cmd_nmi}, 4'h0);
    @(posedge clk_sys);
    nmi <= 1'b0;
    pulse(13'h0400);
    pulse(13'h0800);
    chk_pin({1'b0, tmr_irq, wake_irq, wor_irq}, 4'h7);
    wr(sa, 32'h0, ok);
    settle;
    chk_pin({1'b0, tmr_irq, wake_irq, wor_irq}, 4'h7);
    wr(sa, 32'h0200, ok);
    settle;
    chk_pin({1'b0, tmr_irq, wake_irq, wor_irq}, 4'h3);
    rc(sa, 32'h0, 32'h0280, ok);
    wr(sa, 32'h0080, ok);
    settle;
    chk_pin({1'b0, tmr_irq, wake_irq, wor_irq}, 4'h0);
    @(posedge clk_sys);
    slow <= 1'b1;
    wr(sa, 32'h0C00, ok);
    #1;
    chk_pin({2'h0, gen_req}, 4'h3);
    rc(sa, 32'h0C00, 32'h0C00, ok);
    repeat (16) @(posedge clk_sys);
    #1;
    chk_pin({2'h0, gen_req}, 4'h0);
    pulse(13'h0020);
    chk_pin({3'h0, ev_req}, 4'h1);
    for (int i = 0; i < 40; i++) begin
      rd(sa, rdat, rrsp);
      if (rdat[4] === 1'b0) break;
    end
    chk_reg(rdat, 32'h0, 32'h10);
    settle;
    chk_pin({3'h0, ev_req}, 4'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      pm     <= 2'(i);
      hflags <= 3'(7 - i);
      settle;
      rc(sa, 32'((i << 5) | (7 - i)), 32'h67, ok);
    end
    @(posedge clk_sys);
    pm     <= 2'h0;
    hflags <= 3'h0;
    strb = 4'h1;
    wr(ca, 32'hFFFF, ok);
    strb = 4'hF;
    rc(ca, 32'h0007, 32'hFFFFFFFF, ok);
    wr(ca, 32'hFFFF, ok);
    pulse(13'h0001);
    pulse(13'h1000);
    rc(ca, 32'h0, 32'hFFFFFFFF, ok);
    rc(sa, 32'hC000, 32'hFFFFFFEF, ok);
    chk_pin({1'b0, d2h}, 4'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
